/* hw/spi_port_pkg.sv */
// Shared constants, types and helpers of the serial host port.
package spi_port_pkg;
  // Clock rate and serial clock half period driven by the controller.
  localparam int CLK_MHZ       = 100;
  localparam int SCLK_HALF_NS  = 80;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);

  // Widths and depth of the register space behind the port.
  localparam int ADDR_W     = 13;
  localparam int DATA_W     = 8;
  localparam int CTRL_W     = 16;
  localparam int ADDR_DEPTH = 1 << ADDR_W;

  // Control word layout, first bit on the wire is bit 15.
  localparam int RW_BIT    = 15;
  localparam int ADDR_MSB  = 14;
  localparam int ADDR_LSB  = 2;
  localparam int BURST_BIT = 0;

  // Bit counting inside one byte and frame lengths in bits.
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [4:0] FRAME_FULL = 5'h18;
  localparam logic [4:0] FRAME_DATA = 5'h08;
  localparam logic [4:0] BITS_ONE   = 5'h01;

  // Controller register byte offsets.
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_CONFIG = 5'h14;

  // Command and configuration bit positions.
  localparam int CTL_START     = 0;
  localparam int CTL_READ      = 1;
  localparam int CTL_BURST     = 2;
  localparam int CTL_HOLD      = 3;
  localparam int CTL_DATA_ONLY = 4;
  localparam int CFG_CPOL      = 0;
  localparam int CFG_CPHA      = 1;
  localparam int CFG_SWAP      = 2;

  typedef enum logic [1:0] {PH_CTRL_HI, PH_CTRL_LO, PH_DATA} rx_phase_t;
  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_FIRST, H_SECOND, H_TRAIL} host_state_t;

  // Bit reversal used when the bit order strap asks for LSB first.
  function automatic logic [ADDR_W-1:0] rev_addr(input logic [ADDR_W-1:0] v);
    logic [ADDR_W-1:0] r;
    r = v;
    for (int i = 0; i < ADDR_W; i++) begin
      r[i] = v[ADDR_W-1-i];
    end
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] rev_data(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    r = v;
    for (int i = 0; i < DATA_W; i++) begin
      r[i] = v[DATA_W-1-i];
    end
    return r;
  endfunction
endpackage

/* hw/spi_link_if.sv */
// Four-wire serial link between the controller and the device port.
`timescale 1ns/10ps
interface spi_link_if;
  logic sclk;
  logic mosi;
  logic cs_n;
  logic miso_d;
  logic miso_oe;
  // The device releases the data-out pin when not selected; it reads high then.
  wire  miso = miso_oe ? miso_d : 1'b1;
  modport host (output sclk, output mosi, output cs_n, input miso);
  modport dev  (input sclk, input mosi, input cs_n, output miso_d, output miso_oe);
endinterface

/* hw/sync3.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
module sync3 (
  input  wire logic clk_i,   // Destination clock.
  input  wire logic nrst_i,  // Asynchronous reset, active low.
  input  wire logic d_i,     // Level from another domain.
  output logic      q_o      // Filtered level.
);
  logic [2:0] ff_reg;

  // Stage one feeds only stage two; the output moves once two and three agree.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ff_reg <= 3'h0;
      q_o    <= 1'b0;
    end else begin
      ff_reg <= {ff_reg[1:0], d_i};
      if (ff_reg[1] == ff_reg[2]) begin
        q_o <= ff_reg[2];
      end
    end
  end
endmodule

/* hw/spi_port_host.sv */
// Serial bus master that runs host port accesses on orders from Avalon-MM registers.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
module spi_port_host (
  input  wire logic        clk_i,              // System clock, 100 MHz.
  input  wire logic        nrst_i,             // Asynchronous reset, active low.
  input  wire logic [4:0]  avs_address_i,      // Byte address.
  input  wire logic        avs_read_i,         // Read request.
  input  wire logic        avs_write_i,        // Write request.
  input  wire logic [31:0] avs_writedata_i,    // Write data.
  input  wire logic [3:0]  avs_byteenable_i,   // Byte lanes.
  output logic      [31:0] avs_readdata_o,     // Read data.
  output logic             avs_waitrequest_o,  // Wait request.
  spi_link_if.host         link                // Serial link.
);
  logic                                 busy_reg;
  logic [2:0]                           cfg_reg;
  logic [spi_port_pkg::ADDR_W-1:0]      addr_reg;
  logic [spi_port_pkg::DATA_W-1:0]      wdata_reg;
  logic [spi_port_pkg::DATA_W-1:0]      rd_reg;
  logic [4:0]                           ctl_reg;
  spi_port_pkg::host_state_t            state_reg;
  logic [3:0]                           half_reg;
  logic [4:0]                           left_reg;
  logic [23:0]                          tx_reg;
  logic [spi_port_pkg::DATA_W-1:0]      rx_reg;
  logic                                 miso_s;

  // Bus decode: one wait state, then the access completes.
  wire wr_take = avs_write_i & ~avs_waitrequest_o;
  wire a_ctrl  = avs_address_i == spi_port_pkg::REG_CTRL;
  wire a_addr  = avs_address_i == spi_port_pkg::REG_ADDR;
  wire a_wdat  = avs_address_i == spi_port_pkg::REG_WDATA;
  wire a_rdat  = avs_address_i == spi_port_pkg::REG_RDATA;
  wire a_stat  = avs_address_i == spi_port_pkg::REG_STATUS;
  wire a_cfg   = avs_address_i == spi_port_pkg::REG_CONFIG;
  wire ctl_wr  = wr_take & a_ctrl & avs_byteenable_i[0];
  wire start   = ctl_wr & avs_writedata_i[spi_port_pkg::CTL_START] & ~busy_reg;
  wire release_cs = ctl_wr & ~avs_writedata_i[spi_port_pkg::CTL_START]
                  & ~avs_writedata_i[spi_port_pkg::CTL_HOLD] & ~busy_reg;
  wire [31:0] rd_mux = a_ctrl ? {27'h0000000, ctl_reg[4:1], busy_reg} :
                       a_addr ? {19'h00000, addr_reg} :
                       a_wdat ? {24'h000000, wdata_reg} :
                       a_rdat ? {24'h000000, rd_reg} :
                       a_stat ? {31'h00000000, busy_reg} :
                       a_cfg  ? {29'h00000000, cfg_reg} : 32'h00000000;

  // Frame assembly; bit order follows the same setting as the device strap.
  wire swap  = cfg_reg[spi_port_pkg::CFG_SWAP];
  wire cpol  = cfg_reg[spi_port_pkg::CFG_CPOL];
  wire cpha  = cfg_reg[spi_port_pkg::CFG_CPHA];
  wire first_lvl = cpha ? ~cpol : cpol;
  wire data_only = avs_writedata_i[spi_port_pkg::CTL_DATA_ONLY];
  wire [spi_port_pkg::ADDR_W-1:0] a_ord = swap ? spi_port_pkg::rev_addr(addr_reg) : addr_reg;
  wire [spi_port_pkg::DATA_W-1:0] d_ord = swap ? spi_port_pkg::rev_data(wdata_reg) : wdata_reg;
  wire [spi_port_pkg::CTRL_W-1:0] ctl_word = {avs_writedata_i[spi_port_pkg::CTL_READ], a_ord,
                                              1'b0, avs_writedata_i[spi_port_pkg::CTL_BURST]};
  wire [23:0] frame = data_only ? {d_ord, 16'h0000} : {ctl_word, d_ord};
  wire half_end = half_reg == spi_port_pkg::HALF_LAST;

  // The data-in pin comes from the other side of the link.
  sync3 u_miso_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (link.miso),
    .q_o    (miso_s)
  );

  // Bus handshake: read data settle while waitrequest is low.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= avs_waitrequest_o ? ~(avs_read_i | avs_write_i) : 1'b1;
      avs_readdata_o    <= rd_mux;
    end
  end

  // Software registers; configuration and operands are frozen during a frame.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg   <= 3'h0;
      addr_reg  <= 13'h0000;
      wdata_reg <= 8'h00;
    end else if (wr_take & ~busy_reg) begin
      if (a_cfg & avs_byteenable_i[0]) cfg_reg <= avs_writedata_i[2:0];
      if (a_addr & avs_byteenable_i[0]) addr_reg[7:0] <= avs_writedata_i[7:0];
      if (a_addr & avs_byteenable_i[1]) addr_reg[12:8] <= avs_writedata_i[12:8];
      if (a_wdat & avs_byteenable_i[0]) wdata_reg <= avs_writedata_i[7:0];
    end
  end

  // Half-period timer of the generated serial clock.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_reg <= 4'h0;
    end else begin
      half_reg <= (state_reg == spi_port_pkg::H_IDLE || half_end) ? 4'h0 : half_reg + 4'h1;
    end
  end

  // Link sequencer: each bit is a first half and a second half; sampling at the middle.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= spi_port_pkg::H_IDLE;
      busy_reg  <= 1'b0;
      ctl_reg   <= 5'h00;
      left_reg  <= 5'h00;
      tx_reg    <= 24'h000000;
      rx_reg    <= 8'h00;
      rd_reg    <= 8'h00;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
      link.cs_n <= 1'b1;
    end else begin
      unique case (state_reg)
        spi_port_pkg::H_IDLE: begin
          link.sclk <= cpol;
          if (release_cs) link.cs_n <= 1'b1;
          if (start) begin
            busy_reg <= 1'b1;
            ctl_reg  <= avs_writedata_i[4:0];
            tx_reg   <= frame;
            left_reg <= data_only ? spi_port_pkg::FRAME_DATA : spi_port_pkg::FRAME_FULL;
            link.cs_n <= 1'b0;
            if (link.cs_n) begin
              state_reg <= spi_port_pkg::H_LEAD;
            end else begin
              state_reg <= spi_port_pkg::H_FIRST;
              link.mosi <= frame[23];
              link.sclk <= first_lvl;
            end
          end
        end
        spi_port_pkg::H_LEAD: begin
          if (half_end) begin
            state_reg <= spi_port_pkg::H_FIRST;
            link.mosi <= tx_reg[23];
            link.sclk <= first_lvl;
          end
        end
        spi_port_pkg::H_FIRST: begin
          if (half_end) begin
            state_reg <= spi_port_pkg::H_SECOND;
            link.sclk <= ~first_lvl;
            rx_reg    <= {rx_reg[6:0], miso_s};
          end
        end
        spi_port_pkg::H_SECOND: begin
          if (half_end && left_reg == spi_port_pkg::BITS_ONE) begin
            state_reg <= spi_port_pkg::H_TRAIL;
            link.sclk <= cpol;
          end else if (half_end) begin
            state_reg <= spi_port_pkg::H_FIRST;
            tx_reg    <= {tx_reg[22:0], 1'b0};
            link.mosi <= tx_reg[22];
            link.sclk <= first_lvl;
            left_reg  <= left_reg - 5'h01;
          end
        end
        spi_port_pkg::H_TRAIL: begin
          if (half_end) begin
            state_reg <= spi_port_pkg::H_IDLE;
            busy_reg  <= 1'b0;
            link.cs_n <= ~ctl_reg[spi_port_pkg::CTL_HOLD];
            rd_reg    <= swap ? spi_port_pkg::rev_data(rx_reg) : rx_reg;
          end
        end
      endcase
    end
  end
endmodule

/* hw/spi_port_dev.sv */
// Device end of the serial host port, with its byte-wide register space.
`timescale 1ns/10ps
// Overview of operation
// - Select strap high enables serial slave.
// - Polarity and phase come from straps.
// - Strap sets bit order; flags fixed.
// - Host avoids this port for HDLC.
// - Access is control bytes then data.
// - Master keeps select low within access.
// - Burst advances address, no more control.
// - Without burst, control follows each data.
// - Select high ends access; control first.
// - Phase one samples on trailing edge.
// - Master drives clock; straps match it.
// - Thirteen-bit address, eight-bit data.
module spi_port_dev (
  input  wire logic        clk_i,                  // System clock, 100 MHz.
  input  wire logic        nrst_i,                 // Device reset, active low.
  input  wire logic        serial_select_strap_i,  // High selects the serial port.
  input  wire logic        clock_polarity_strap_i, // Idle level of the serial clock.
  input  wire logic        clock_phase_strap_i,    // Sampling edge choice.
  input  wire logic        bit_order_strap_i,      // High sends address and data LSB first.
  spi_link_if.dev          link,                   // Serial link.
  output logic             wr_strobe_o,            // One-cycle pulse per byte written.
  output logic [12:0]      wr_addr_o,              // Address of that byte.
  output logic [7:0]       wr_data_o               // Value of that byte.
);
  // Strap copies, caught in the system clock domain.
  logic                              strap_done_reg;
  logic                              sel_reg;
  logic                              cpol_reg;
  logic                              cpha_reg;
  logic                              swap_reg;

  // Link-side frame state.
  spi_port_pkg::rx_phase_t           phase_reg;
  logic [2:0]                        bit_reg;
  logic [spi_port_pkg::DATA_W-1:0]   in_reg;
  logic [spi_port_pkg::DATA_W-1:0]   hi_reg;
  logic                              rw_reg;
  logic                              burst_reg;
  logic [spi_port_pkg::ADDR_W-1:0]   addr_reg;
  logic [spi_port_pkg::DATA_W-1:0]   rd_byte_reg;
  logic                              miso_reg;

  // Write report crossing.
  logic                              wr_tgl_reg;
  logic [spi_port_pkg::ADDR_W-1:0]   hold_addr_reg;
  logic [spi_port_pkg::DATA_W-1:0]   hold_data_reg;
  logic                              wr_tgl_s;
  logic                              tgl_seen_reg;

  // The register space itself.
  logic [spi_port_pkg::DATA_W-1:0]   mem [spi_port_pkg::ADDR_DEPTH];

  // Straps are caught once at the first edge after reset and then held; a strap
  // changed later has no effect until the next reset.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_reg <= 1'b0;
      sel_reg        <= 1'b0;
      cpol_reg       <= 1'b0;
      cpha_reg       <= 1'b0;
      swap_reg       <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      sel_reg        <= serial_select_strap_i;
      cpol_reg       <= clock_polarity_strap_i;
      cpha_reg       <= clock_phase_strap_i;
      swap_reg       <= bit_order_strap_i;
    end
  end

  // edge choice
  // The sampling edge is always a rising edge of this derived clock; outputs
  // move on its falling edge, half a bit ahead of the master's sample.
  wire sample_clk = link.sclk ^ cpol_reg ^ cpha_reg;

  // select high ends access
  // A frame lives only while select is low; the link clock may stop outside
  // frames, so the frame itself is cleared by select rather than by a clock edge.
  wire frame_rst_n = nrst_i & ~link.cs_n & sel_reg;

  // Byte assembly and control word decode.
  wire [spi_port_pkg::DATA_W-1:0] byte_full = {in_reg[6:0], link.mosi};
  wire                            byte_done = bit_reg == spi_port_pkg::BIT_LAST;
  wire [spi_port_pkg::CTRL_W-1:0] ctl_word  = {hi_reg, byte_full};
  wire [spi_port_pkg::ADDR_W-1:0] ctl_raw   = ctl_word[spi_port_pkg::ADDR_MSB:spi_port_pkg::ADDR_LSB];
  wire [spi_port_pkg::ADDR_W-1:0] ctl_addr  = swap_reg ? spi_port_pkg::rev_addr(ctl_raw) : ctl_raw;
  wire [spi_port_pkg::DATA_W-1:0] data_byte =
    swap_reg ? spi_port_pkg::rev_data(byte_full) : byte_full;
  wire [spi_port_pkg::ADDR_W-1:0] addr_inc  = addr_reg + 13'h0001;
  wire                            data_done = byte_done && phase_reg == spi_port_pkg::PH_DATA;
  wire                            wr_fire   = data_done && !rw_reg;
  wire [2:0]                      out_idx   = swap_reg ? bit_reg : spi_port_pkg::BIT_LAST - bit_reg;

  // Frame parser: two control bytes, then data bytes.
  always_ff @(posedge sample_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase_reg   <= spi_port_pkg::PH_CTRL_HI;
      bit_reg     <= 3'h0;
      in_reg      <= 8'h00;
      hi_reg      <= 8'h00;
      rw_reg      <= 1'b0;
      burst_reg   <= 1'b0;
      addr_reg    <= 13'h0000;
      rd_byte_reg <= 8'h00;
    end else begin
      bit_reg <= bit_reg + 3'h1;
      in_reg  <= byte_full;
      if (byte_done) begin
        unique case (phase_reg)
          spi_port_pkg::PH_CTRL_HI: begin
            hi_reg    <= byte_full;
            phase_reg <= spi_port_pkg::PH_CTRL_LO;
          end
          spi_port_pkg::PH_CTRL_LO: begin
            rw_reg      <= ctl_word[spi_port_pkg::RW_BIT];
            burst_reg   <= ctl_word[spi_port_pkg::BURST_BIT];
            addr_reg    <= ctl_addr;
            rd_byte_reg <= mem[ctl_addr];
            phase_reg   <= spi_port_pkg::PH_DATA;
          end
          spi_port_pkg::PH_DATA: begin
            if (burst_reg) begin
              addr_reg    <= addr_inc;
              rd_byte_reg <= mem[addr_inc];
            end else begin
              phase_reg <= spi_port_pkg::PH_CTRL_HI;
            end
          end
        endcase
      end
    end
  end

  // byte-wide storage
  // The array has no reset; software is expected to initialise what it uses.
  always_ff @(posedge sample_clk) begin
    if (frame_rst_n && wr_fire) begin
      mem[addr_reg] <= data_byte;
    end
  end

  // read data out
  // Output data move on the non-sampling edge so they are stable a half bit later.
  always_ff @(negedge sample_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      miso_reg <= 1'b1;
    end else begin
      miso_reg <= rd_byte_reg[out_idx];
    end
  end

  assign link.miso_d  = miso_reg;
  assign link.miso_oe = ~link.cs_n & sel_reg;

  // Each written byte flips a toggle; address and value stay put until the next
  // write, which is at least eight link clocks away.
  always_ff @(posedge sample_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_tgl_reg    <= 1'b0;
      hold_addr_reg <= 13'h0000;
      hold_data_reg <= 8'h00;
    end else if (frame_rst_n && wr_fire) begin
      wr_tgl_reg    <= ~wr_tgl_reg;
      hold_addr_reg <= addr_reg;
      hold_data_reg <= data_byte;
    end
  end

  sync3 u_wr_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (wr_tgl_reg),
    .q_o    (wr_tgl_s)
  );

  // Turn each toggle change into one strobe in the system clock domain.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tgl_seen_reg <= 1'b0;
      wr_strobe_o  <= 1'b0;
      wr_addr_o    <= 13'h0000;
      wr_data_o    <= 8'h00;
    end else begin
      tgl_seen_reg <= wr_tgl_s;
      wr_strobe_o  <= wr_tgl_s ^ tgl_seen_reg;
      if (wr_tgl_s ^ tgl_seen_reg) begin
        wr_addr_o <= hold_addr_reg;
        wr_data_o <= hold_data_reg;
      end
    end
  end
endmodule

/* verif/spi_link_checker.sv */
// Assertions on the serial link between the controller and the device port.
`timescale 1ns/10ps
module spi_link_checker (
  input wire logic clk_i,                  // System clock.
  input wire logic nrst_i,                 // Reset, active low.
  input wire logic serial_select_strap_i,  // Serial port enable strap.
  input wire logic clock_polarity_strap_i, // Idle clock level strap.
  input wire logic clock_phase_strap_i,    // Sampling edge strap.
  input wire logic sclk,                   // Serial clock.
  input wire logic mosi,                   // Controller to device data.
  input wire logic cs_n,                   // Frame select, active low.
  input wire logic miso_d,                 // Device data out.
  input wire logic miso_oe                 // Device output enable.
);
  logic       sclk_q;
  logic [2:0] edge_cnt;
  // A sampling edge: leading edge for phase zero, trailing edge for phase one.
  wire        samp_edge = !cs_n && (sclk != sclk_q)
                          && (sclk ^ clock_polarity_strap_i ^ clock_phase_strap_i);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Count sampling edges in a frame, because a frame may only carry whole bytes.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_q   <= 1'b0;
      edge_cnt <= 3'h0;
    end else begin
      sclk_q   <= sclk;
      edge_cnt <= cs_n ? 3'h0 : edge_cnt + 3'(samp_edge);
    end
  end

  property p_oe_select; (!cs_n && serial_select_strap_i) |-> miso_oe; endproperty
  a_oe_select: assert property (p_oe_select) else $error("data out idle while selected");
  property p_released; cs_n |-> !miso_oe; endproperty
  a_released: assert property (p_released) else $error("data out driven while idle");
  property p_idle_level; $fell(cs_n) |-> sclk == clock_polarity_strap_i; endproperty
  a_idle_level: assert property (p_idle_level) else $error("wrong idle clock level");
  property p_lead; $fell(cs_n) |-> $stable(sclk)[*7]; endproperty
  a_lead: assert property (p_lead) else $error("clock moved right after select");
  property p_half; (!cs_n && $changed(sclk)) |=> $stable(sclk)[*7]; endproperty
  a_half: assert property (p_half) else $error("serial clock half period too short");
  property p_mosi_setup; samp_edge |-> $stable(mosi) ##1 $stable(mosi); endproperty
  a_mosi_setup: assert property (p_mosi_setup) else $error("data in moved at sample");
  property p_miso_hold; (samp_edge && miso_oe) |-> $stable(miso_d); endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("data out moved at sample");
  property p_whole_bytes; $rose(cs_n) |-> edge_cnt == 3'h0; endproperty
  a_whole_bytes: assert property (p_whole_bytes) else $error("frame not whole bytes");
endmodule

/* verif/tb_top.sv */
// Self-checking bench: controller and device port joined over the serial link.
`timescale 1ns/10ps
module tb_top;
  logic        clk_i;
  logic        nrst_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [2:0]  mode;
  logic        sel;
  logic        wr_strobe_o;
  logic [12:0] wr_addr_o;
  logic [7:0]  wr_data_o;
  logic [12:0] got_addr;
  logic [7:0]  got_data;
  logic [31:0] rdata;
  int          num_errors;
  int          comparisons;
  int          cycles;
  int          strobes;

  spi_link_if link ();

  spi_port_host spi_port_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .link(link));

  spi_port_dev spi_port_dev_i (.clk_i(clk_i), .nrst_i(nrst_i), .serial_select_strap_i(sel),
    .clock_polarity_strap_i(mode[0]), .clock_phase_strap_i(mode[1]),
    .bit_order_strap_i(mode[2]), .link(link), .wr_strobe_o(wr_strobe_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));

  spi_link_checker spi_link_checker_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .serial_select_strap_i(sel), .clock_polarity_strap_i(mode[0]),
    .clock_phase_strap_i(mode[1]), .sclk(link.sclk), .mosi(link.mosi), .cs_n(link.cs_n),
    .miso_d(link.miso_d), .miso_oe(link.miso_oe));

  // The clock is free running at 100 MHz.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Record each reported byte write; a hang is cut short by a cycle ceiling.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (wr_strobe_o === 1'b1) begin
      got_addr <= wr_addr_o;
      got_data <= wr_data_o;
      strobes  <= strobes + 1;
    end
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One bus cycle: the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  // Load address and data, issue a command, then poll until the frame is done.
  task automatic xfer(input logic [12:0] a, input logic [7:0] d, input logic [4:0] c);
    int n;
    n = 0;
    bus(1'b1, spi_port_pkg::REG_ADDR, 32'(a));
    bus(1'b1, spi_port_pkg::REG_WDATA, 32'(d));
    bus(1'b1, spi_port_pkg::REG_CTRL, 32'(c));
    do begin
      bus(1'b0, spi_port_pkg::REG_STATUS, 32'h0);
      n++;
    end while (rdata[0] !== 1'b0 && n < 400);
    if (n >= 400) num_errors++;
    repeat (8) @(posedge clk_i);
  endtask

  // Straps are caught only after reset, so each mode needs its own reset.
  task automatic do_reset(input logic [2:0] m);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    mode   <= m;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    bus(1'b1, spi_port_pkg::REG_CONFIG, 32'(m));
  endtask

  task automatic summarize();
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Every clock polarity, phase and bit order in turn.
  initial begin
    nrst_i          <= 1'b0;
    mode            <= 3'h0;
    sel             <= 1'b1;
    avs_address_i   <= 5'h00;
    avs_read_i      <= 1'b0;
    avs_write_i     <= 1'b0;
    avs_writedata_i <= 32'h0;
    for (int m = 0; m < 8; m++) begin
      do_reset(3'(m));
      xfer(13'h1555 ^ 13'(m), 8'hA5 ^ 8'(m), 5'h01);
      check(32'(got_addr), 32'(13'h1555 ^ 13'(m)));
      check(32'(got_data), 32'(8'hA5 ^ 8'(m)));
      xfer(13'h1555 ^ 13'(m), 8'h00, 5'h03);
      bus(1'b0, spi_port_pkg::REG_RDATA, 32'h0);
      check(rdata, 32'(8'hA5 ^ 8'(m)));
      // A burst at the top address wraps to zero with select held.
      xfer(13'h1FFF, 8'h3C, 5'h0D);
      xfer(13'h1FFF, 8'hC3, 5'h1D);
      check(32'(got_addr), 32'h0);
      check(32'(got_data), 32'hC3);
      bus(1'b1, spi_port_pkg::REG_CTRL, 32'h0);
      repeat (4) @(posedge clk_i);
      check(32'(link.cs_n), 32'h1);
      // Without burst, a held select still takes a fresh control word.
      xfer(13'h0123, 8'h5A, 5'h09);
      xfer(13'h0ABC, 8'h96, 5'h01);
      check(32'(got_addr), 32'h0ABC);
      check(32'(link.sclk), 32'(mode[0]));
      xfer(13'h0000, 8'h00, 5'h03);
      bus(1'b0, spi_port_pkg::REG_RDATA, 32'h0);
      check(rdata, 32'hC3);
      bus(1'b0, 5'h18, 32'h0);
      check(rdata, 32'h0);
      check(32'(strobes), 32'(5 * (m + 1)));
    end
    // strap low, port ignores the link; its released data-out pin reads high.
    sel <= 1'b0;
    do_reset(3'h0);
    xfer(13'h0042, 8'h11, 5'h01);
    xfer(13'h0042, 8'h00, 5'h03);
    bus(1'b0, spi_port_pkg::REG_RDATA, 32'h0);
    check(rdata, 32'h000000FF);
    check(32'(strobes), 32'h00000028);
    summarize();
  end
endmodule
